// ---- rtl/ilp_edge_sync.sv ----
// two-stage synchroniser with falling-edge pulse for a pin input
`timescale 1ns/1ns
module ilp_edge_sync
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  always_comb
  begin
    nxt_meta = pin;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // idle high so a high pin at release is no edge; a low pin at release gives one fall pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level = sync_ff;
  assign fall  = prev_ff & ~sync_ff;
endmodule

// ---- rtl/ilp_pkg.sv ----
// types shared by the irq/low-power block
package ilp_pkg;
  typedef enum logic [1:0]
  {
    ILP_ACTIVE  = 2'h0,
    ILP_STANDBY = 2'h1,
    ILP_STOP    = 2'h3
  } ilp_mode_t;

  // one bit per source, highest priority first
  typedef struct packed
  {
    logic ext;
    logic tb;
    logic tc;
    logic ad;
    logic ser;
  } ilp_src_t;
endpackage

// ---- rtl/ilp_regs.svh ----
// register offsets, bit positions and reset values of the irq/low-power block
`ifndef ILP_REGS_SVH
`define ILP_REGS_SVH
`define ILP_AW             10
`define ILP_ADDR_CTRL0     10'h000
`define ILP_ADDR_TIMER     10'h002
`define ILP_ADDR_ADSER     10'h003
`define ILP_ADDR_RAMKEPT   10'h021
`define ILP_BIT_IE         0
`define ILP_BIT_EXT_PEND   2
`define ILP_BIT_EXT_MASK   3
`define ILP_BIT_TB_PEND    0
`define ILP_BIT_TB_MASK    1
`define ILP_BIT_TC_PEND    2
`define ILP_BIT_TC_MASK    3
`define ILP_BIT_AD_PEND    0
`define ILP_BIT_AD_MASK    1
`define ILP_BIT_SER_PEND   2
`define ILP_BIT_SER_MASK   3
`define ILP_BIT_RAMKEPT    3
`define ILP_RST_PEND       5'h00
`define ILP_RST_MASK       5'h1F
`define ILP_VEC_EXT        3'h0
`define ILP_VEC_TB         3'h1
`define ILP_VEC_TC         3'h2
`define ILP_VEC_AD         3'h3
`define ILP_VEC_SER        3'h4
`endif

// ---- rtl/ilp_top.sv ----
// interrupt flags, masks, enable and power-mode control
`timescale 1ns/1ns
`include "ilp_regs.svh"
module ilp_top
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [`ILP_AW-1:0]  ram_addr,
  input  wire logic                ram_wr,
  input  wire logic [3:0]          ram_wdata,
  output logic [3:0]               ram_rdata,
  output logic                     ram_hit,
  input  wire logic                ext_func_sel,
  input  wire logic                external_irq_input_n,
  input  wire logic                stop_release_pin_n,
  input  wire ilp_pkg::ilp_src_t   periph_event,
  input  wire logic                standby_instruction,
  input  wire logic                stop_instruction,
  input  wire logic                return_from_interrupt_instruction,
  input  wire logic                irq_take,
  input  wire logic                instr_done,
  output logic                     irq_req,
  output logic [2:0]               irq_vector,
  output logic                     sleep_cancel,
  output logic                     cpu_clk_en,
  output logic                     osc_run,
  output logic                     periph_reset,
  output logic                     port_hold,
  output logic                     restart_at_zero,
  output logic                     ram_kept_flag
);
  ilp_pkg::ilp_mode_t mode_ff;
  ilp_pkg::ilp_mode_t nxt_mode;
  ilp_pkg::ilp_src_t  pend_ff;
  ilp_pkg::ilp_src_t  nxt_pend;
  ilp_pkg::ilp_src_t  mask_ff;
  ilp_pkg::ilp_src_t  nxt_mask;
  ilp_pkg::ilp_src_t  set_ev;
  ilp_pkg::ilp_src_t  clr_ev;
  ilp_pkg::ilp_src_t  live;
  logic               ie_ff;
  logic               nxt_ie;
  logic               ram_kept_ff;
  logic               nxt_ram_kept;
  logic               wake_hold_ff;
  logic               nxt_wake_hold;
  logic               irq_req_ff;
  logic               nxt_irq_req;
  logic [2:0]         vec_ff;
  logic [2:0]         nxt_vec;
  logic               cancel_ff;
  logic               nxt_cancel;
  logic               restart_ff;
  logic               nxt_restart;
  logic [3:0]         rdata_ff;
  logic [3:0]         nxt_rdata;
  logic               hit_ff;
  logic               nxt_hit;
  logic               ext_fall;
  logic               release_level_n;
  logic               any_live;
  logic               sleep_req;

  function automatic logic wr_clr(input logic [`ILP_AW-1:0] a,
                                  input logic [`ILP_AW-1:0] reg_a,
                                  input logic [3:0]         d,
                                  input int                 b);
    wr_clr = ram_wr && (a == reg_a) && !d[b];
  endfunction

  function automatic logic [2:0] prio_vec(input ilp_pkg::ilp_src_t s);
    if (s.ext)
      prio_vec = `ILP_VEC_EXT;
    else if (s.tb)
      prio_vec = `ILP_VEC_TB;
    else if (s.tc)
      prio_vec = `ILP_VEC_TC;
    else if (s.ad)
      prio_vec = `ILP_VEC_AD;
    else
      prio_vec = `ILP_VEC_SER;
  endfunction

  ilp_edge_sync u_ext_sync
  (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (external_irq_input_n),
    .level (),
    .fall  (ext_fall)
  );

  // release pin is low-active; held low for the stabilisation time
  ilp_edge_sync u_rel_sync
  (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (stop_release_pin_n),
    .level (release_level_n),
    .fall  ()
  );

  assign live      = pend_ff & ~mask_ff;
  assign any_live  = |live;
  assign sleep_req = standby_instruction | stop_instruction;

  // flag and mask state
  always_comb
  begin
    set_ev     = periph_event;
    set_ev.ext = ext_fall && ext_func_sel;
    clr_ev.ext = wr_clr(ram_addr, `ILP_ADDR_CTRL0, ram_wdata,
                        `ILP_BIT_EXT_PEND);
    clr_ev.tb  = wr_clr(ram_addr, `ILP_ADDR_TIMER, ram_wdata,
                        `ILP_BIT_TB_PEND);
    clr_ev.tc  = wr_clr(ram_addr, `ILP_ADDR_TIMER, ram_wdata,
                        `ILP_BIT_TC_PEND);
    clr_ev.ad  = wr_clr(ram_addr, `ILP_ADDR_ADSER, ram_wdata,
                        `ILP_BIT_AD_PEND);
    clr_ev.ser = wr_clr(ram_addr, `ILP_ADDR_ADSER, ram_wdata,
                        `ILP_BIT_SER_PEND);
    // writing 1 to a flag does nothing; set beats clear
    nxt_pend = (pend_ff & ~clr_ev) | set_ev;
    nxt_mask = mask_ff;
    nxt_ie   = ie_ff;
    if (ram_wr && ram_addr == `ILP_ADDR_CTRL0)
    begin
      nxt_ie       = ram_wdata[`ILP_BIT_IE];
      nxt_mask.ext = ram_wdata[`ILP_BIT_EXT_MASK];
    end
    if (ram_wr && ram_addr == `ILP_ADDR_TIMER)
    begin
      nxt_mask.tb = ram_wdata[`ILP_BIT_TB_MASK];
      nxt_mask.tc = ram_wdata[`ILP_BIT_TC_MASK];
    end
    if (ram_wr && ram_addr == `ILP_ADDR_ADSER)
    begin
      nxt_mask.ad  = ram_wdata[`ILP_BIT_AD_MASK];
      nxt_mask.ser = ram_wdata[`ILP_BIT_SER_MASK];
    end
    if (return_from_interrupt_instruction)
      nxt_ie = 1'b1;
    if (irq_take)
      nxt_ie = 1'b0;
    // stop holds flags, masks and enable in their reset state
    if (mode_ff == ilp_pkg::ILP_STOP)
    begin
      nxt_pend = `ILP_RST_PEND;
      nxt_mask = `ILP_RST_MASK;
      nxt_ie   = 1'b0;
    end
  end

  // power-mode state
  always_comb
  begin
    nxt_mode      = mode_ff;
    nxt_ram_kept  = ram_kept_ff;
    nxt_wake_hold = wake_hold_ff;
    nxt_cancel    = 1'b0;
    nxt_restart   = 1'b0;
    if (ram_wr && ram_addr == `ILP_ADDR_RAMKEPT)
      nxt_ram_kept = ram_wdata[`ILP_BIT_RAMKEPT];
    if (instr_done)
      nxt_wake_hold = 1'b0;
    unique case (mode_ff)
      ilp_pkg::ILP_ACTIVE:
      begin
        if (sleep_req && !ie_ff && any_live)
          nxt_cancel = 1'b1;
        else if (stop_instruction)
          nxt_mode = ilp_pkg::ILP_STOP;
        else if (standby_instruction)
          nxt_mode = ilp_pkg::ILP_STANDBY;
      end
      ilp_pkg::ILP_STANDBY:
      begin
        // wake on any unmasked flag, whatever the enable
        if (any_live)
        begin
          nxt_mode      = ilp_pkg::ILP_ACTIVE;
          nxt_wake_hold = 1'b1;
        end
      end
      ilp_pkg::ILP_STOP:
      begin
        if (!release_level_n)
        begin
          nxt_mode     = ilp_pkg::ILP_ACTIVE;
          nxt_ram_kept = 1'b1;
          nxt_restart  = 1'b1;
        end
      end
      default:
        nxt_mode = ilp_pkg::ILP_ACTIVE;
    endcase
  end

  // request, vector and read-back
  always_comb
  begin
    nxt_irq_req = ie_ff && any_live && !wake_hold_ff
                  && mode_ff == ilp_pkg::ILP_ACTIVE;
    nxt_vec     = prio_vec(live);
    nxt_hit     = 1'b1;
    nxt_rdata   = 4'h0;
    unique case (ram_addr)
      `ILP_ADDR_CTRL0:
        nxt_rdata = {mask_ff.ext, pend_ff.ext, 1'b0, ie_ff};
      `ILP_ADDR_TIMER:
        nxt_rdata = {mask_ff.tc, pend_ff.tc, mask_ff.tb, pend_ff.tb};
      `ILP_ADDR_ADSER:
        nxt_rdata = {mask_ff.ser, pend_ff.ser, mask_ff.ad, pend_ff.ad};
      `ILP_ADDR_RAMKEPT:
        nxt_rdata = {ram_kept_ff, 3'h0};
      default:
        nxt_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_ff      <= ilp_pkg::ILP_ACTIVE;
      pend_ff      <= `ILP_RST_PEND;
      mask_ff      <= `ILP_RST_MASK;
      ie_ff        <= 1'b0;
      ram_kept_ff  <= 1'b0;
      wake_hold_ff <= 1'b0;
      irq_req_ff   <= 1'b0;
      vec_ff       <= 3'h0;
      cancel_ff    <= 1'b0;
      restart_ff   <= 1'b0;
      rdata_ff     <= 4'h0;
      hit_ff       <= 1'b0;
    end
    else
    begin
      mode_ff      <= nxt_mode;
      pend_ff      <= nxt_pend;
      mask_ff      <= nxt_mask;
      ie_ff        <= nxt_ie;
      ram_kept_ff  <= nxt_ram_kept;
      wake_hold_ff <= nxt_wake_hold;
      irq_req_ff   <= nxt_irq_req;
      vec_ff       <= nxt_vec;
      cancel_ff    <= nxt_cancel;
      restart_ff   <= nxt_restart;
      rdata_ff     <= nxt_rdata;
      hit_ff       <= nxt_hit;
    end
  end

  assign irq_req         = irq_req_ff;
  assign irq_vector      = vec_ff;
  assign sleep_cancel    = cancel_ff;
  assign restart_at_zero = restart_ff;
  assign ram_kept_flag   = ram_kept_ff;
  assign ram_rdata       = rdata_ff;
  assign ram_hit         = hit_ff;
  // RAM itself lives outside and is never cleared here
  assign cpu_clk_en   = mode_ff == ilp_pkg::ILP_ACTIVE;
  assign osc_run      = mode_ff != ilp_pkg::ILP_STOP;
  assign periph_reset = mode_ff == ilp_pkg::ILP_STOP;
  assign port_hold    = mode_ff == ilp_pkg::ILP_STANDBY;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_stop_release;
    mode_ff == ilp_pkg::ILP_STOP && !release_level_n;
  endsequence

  sequence s_active_kept;
    mode_ff == ilp_pkg::ILP_ACTIVE && ram_kept_ff && restart_ff;
  endsequence

  a_take_clears_ie: assert property (
    irq_take |=> !ie_ff)
    else $error("enable not cleared by interrupt entry");

  a_rti_sets_ie: assert property (
    return_from_interrupt_instruction && !irq_take
    && mode_ff != ilp_pkg::ILP_STOP |=> ie_ff)
    else $error("enable not set by return");

  a_ext_edge_flag: assert property (
    ext_fall && ext_func_sel && mode_ff != ilp_pkg::ILP_STOP
    |=> pend_ff.ext)
    else $error("external edge lost");

  a_set_beats_clr: assert property (
    periph_event.tb && clr_ev.tb && mode_ff != ilp_pkg::ILP_STOP
    |=> pend_ff.tb)
    else $error("timer B set lost to clear");

  a_req_gated_ie: assert property (
    irq_req |-> $past(ie_ff) && $past(any_live))
    else $error("request without enable or live flag");

  a_prio_ext_first: assert property (
    live.ext |=> irq_vector == `ILP_VEC_EXT)
    else $error("external not highest priority");

  a_sleep_cancel: assert property (
    mode_ff == ilp_pkg::ILP_ACTIVE && sleep_req && !ie_ff && any_live
    |=> sleep_cancel && mode_ff == ilp_pkg::ILP_ACTIVE)
    else $error("sleep not cancelled");

  a_standby_wake: assert property (
    mode_ff == ilp_pkg::ILP_STANDBY && any_live
    |=> cpu_clk_en && !irq_req ##1 !irq_req)
    else $error("standby wake wrong");

  a_stop_release: assert property (
    s_stop_release |=> s_active_kept)
    else $error("stop release did not restart with flag");

  a_release_ignored: assert property (
    mode_ff != ilp_pkg::ILP_STOP && !ram_wr |=> $stable(ram_kept_ff))
    else $error("release acted outside stop");

  a_stop_held: assert property (
    mode_ff == ilp_pkg::ILP_STOP |-> periph_reset && !osc_run
    && !cpu_clk_en)
    else $error("stop mode not holding");

  a_reset_values: assert property (
    @(posedge clk) disable iff (1'b0)
    !nrst |=> !ie_ff && mask_ff == `ILP_RST_MASK
    && pend_ff == `ILP_RST_PEND)
    else $error("reset values wrong");
endmodule

// ---- verification/ilp_cpu_model.sv ----
// cpu core and peripheral request model facing the irq/low-power block
`timescale 1ns/1ns
module ilp_cpu_model
(
  input  wire logic         clk,
  input  wire logic         irq_req,
  output ilp_pkg::ilp_src_t periph_event,
  output logic              standby_instruction,
  output logic              stop_instruction,
  output logic              return_from_interrupt_instruction,
  output logic              irq_take,
  output logic              instr_done,
  output logic              ext_func_sel,
  output logic              external_irq_input_n,
  output logic              stop_release_pin_n
);
  logic [3:0] ops;
  bit         auto_take;
  int         take_dly;
  int         wait_cnt;

  assign {instr_done, return_from_interrupt_instruction} = ops[3:2];
  assign {stop_instruction, standby_instruction} = ops[1:0];

  initial
  begin
    ops = 4'h0;
    periph_event = 5'h00;
    irq_take = 1'b0;
    ext_func_sel = 1'b0;
    external_irq_input_n = 1'b1;
    stop_release_pin_n = 1'b1;
    auto_take = 1'b0;
    take_dly = 0;
    wait_cnt = 0;
  end

  // one-shot take so a late falling request is not taken twice
  always @(posedge clk)
  begin
    irq_take <= 1'b0;
    if (auto_take && irq_req === 1'b1 && !irq_take)
    begin
      if (wait_cnt >= take_dly)
      begin
        irq_take <= 1'b1;
        auto_take <= 1'b0;
        wait_cnt <= 0;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end

  // bits: instr done, return, stop, standby
  task automatic op(input logic [3:0] v);
    @(posedge clk);
    ops <= v;
    @(posedge clk);
    ops <= 4'h0;
  endtask

  task automatic ev(input ilp_pkg::ilp_src_t s);
    @(posedge clk);
    periph_event <= s;
    @(posedge clk);
    periph_event <= 5'h00;
  endtask

  task automatic ext_fall(input logic sel);
    @(posedge clk);
    ext_func_sel <= sel;
    external_irq_input_n <= 1'b0;
    repeat (4) @(posedge clk);
    external_irq_input_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // held low across the whole settling time before letting go
  task automatic release_stop(input int n);
    @(posedge clk);
    stop_release_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    stop_release_pin_n <= 1'b1;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the irq/low-power block
`timescale 1ns/1ns
`include "ilp_regs.svh"
module tb_top;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic [`ILP_AW-1:0] ram_addr = '0;
  logic               ram_wr = 1'b0;
  logic [3:0]         ram_wdata = 4'h0;
  logic [3:0]         ram_rdata;
  logic [2:0]         irq_vector;
  logic               ram_hit, irq_req, sleep_cancel, cpu_clk_en, osc_run;
  logic               periph_reset, port_hold, restart_at_zero, ram_kept_flag;
  ilp_pkg::ilp_src_t  periph_event;
  logic               standby_instruction, stop_instruction, irq_take;
  logic               return_from_interrupt_instruction, instr_done;
  logic               ext_func_sel, external_irq_input_n, stop_release_pin_n;
  int                 fail_count, samples_checked, cycles, restarts;
  logic [9:0]         ta [5] = '{10'h003, 10'h003, 10'h002, 10'h002, 10'h000};
  logic [3:0]         tv [5] = '{4'h7, 4'h5, 4'h7, 4'h5, 4'h5};

  always #4 clk = ~clk;

  ilp_top u_ilp_top
  (
    .clk                               (clk),
    .nrst                              (nrst),
    .ram_addr                          (ram_addr),
    .ram_wr                            (ram_wr),
    .ram_wdata                         (ram_wdata),
    .ram_rdata                         (ram_rdata),
    .ram_hit                           (ram_hit),
    .ext_func_sel                      (ext_func_sel),
    .external_irq_input_n              (external_irq_input_n),
    .stop_release_pin_n                (stop_release_pin_n),
    .periph_event                      (periph_event),
    .standby_instruction               (standby_instruction),
    .stop_instruction                  (stop_instruction),
    .return_from_interrupt_instruction (return_from_interrupt_instruction),
    .irq_take                          (irq_take),
    .instr_done                        (instr_done),
    .irq_req                           (irq_req),
    .irq_vector                        (irq_vector),
    .sleep_cancel                      (sleep_cancel),
    .cpu_clk_en                        (cpu_clk_en),
    .osc_run                           (osc_run),
    .periph_reset                      (periph_reset),
    .port_hold                         (port_hold),
    .restart_at_zero                   (restart_at_zero),
    .ram_kept_flag                     (ram_kept_flag)
  );

  ilp_cpu_model u_ilp_cpu_model
  (
    .clk                               (clk),
    .irq_req                           (irq_req),
    .periph_event                      (periph_event),
    .standby_instruction               (standby_instruction),
    .stop_instruction                  (stop_instruction),
    .return_from_interrupt_instruction (return_from_interrupt_instruction),
    .irq_take                          (irq_take),
    .instr_done                        (instr_done),
    .ext_func_sel                      (ext_func_sel),
    .external_irq_input_n              (external_irq_input_n),
    .stop_release_pin_n                (stop_release_pin_n)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // run is under two hundred cycles, so this ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles++;
    if (restart_at_zero === 1'b1)
      restarts++;
    if (cycles == 3000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [3:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    @(posedge clk);
    ram_addr <= a;
    ram_wr <= 1'b1;
    ram_wdata <= d;
    @(posedge clk);
    ram_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [3:0] exp);
    @(posedge clk);
    ram_addr <= a;
    cyc(1);
    check("rdata", ram_rdata, exp);
    check("hit", {3'h0, ram_hit}, 4'h1);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`ILP_ADDR_CTRL0, 4'h8);
    rd(`ILP_ADDR_TIMER, 4'hA);
    rd(`ILP_ADDR_ADSER, 4'hA);
    rd(`ILP_ADDR_RAMKEPT, 4'h0);
    @(posedge clk);
    ram_addr <= 10'h001;
    cyc(2);
    check("hit", {3'h0, ram_hit}, 4'h0);
    u_ilp_cpu_model.ev(5'h0F);
    rd(`ILP_ADDR_TIMER, 4'hF);
    rd(`ILP_ADDR_ADSER, 4'hF);
    u_ilp_cpu_model.ext_fall(1'b0);
    rd(`ILP_ADDR_CTRL0, 4'h8);
    u_ilp_cpu_model.ext_fall(1'b1);
    rd(`ILP_ADDR_CTRL0, 4'hC);
    // flag clear and same-edge hardware set
    fork
      wr(`ILP_ADDR_TIMER, 4'hF);
      u_ilp_cpu_model.ev(5'h08);
    join
    rd(`ILP_ADDR_TIMER, 4'hF);
    fork
      wr(`ILP_ADDR_TIMER, 4'hA);
      u_ilp_cpu_model.ev(5'h08);
    join
    rd(`ILP_ADDR_TIMER, 4'hB);
    u_ilp_cpu_model.ev(5'h0F);
    wr(`ILP_ADDR_CTRL0, 4'hD);
    cyc(2);
    check("irq_req", {3'h0, irq_req}, 4'h0);
    // unmask from lowest priority upward
    for (int i = 0; i < 5; i++)
    begin
      wr(ta[i], tv[i]);
      cyc(2);
      check("irq_req", {3'h0, irq_req}, 4'h1);
      check("vector", {1'b0, irq_vector}, 4'(4 - i));
    end
    wr(`ILP_ADDR_CTRL0, 4'h4);
    cyc(2);
    check("irq_req", {3'h0, irq_req}, 4'h0);
    wr(`ILP_ADDR_CTRL0, 4'h5);
    u_ilp_cpu_model.auto_take = 1'b1;
    cyc(4);
    rd(`ILP_ADDR_CTRL0, 4'h4);
    u_ilp_cpu_model.op(4'h4);
    rd(`ILP_ADDR_CTRL0, 4'h5);
    wr(`ILP_ADDR_CTRL0, 4'h0);
    wr(`ILP_ADDR_TIMER, 4'h0);
    wr(`ILP_ADDR_ADSER, 4'h0);
    u_ilp_cpu_model.ev(5'h08);
    for (int k = 0; k < 2; k++)
    begin
      u_ilp_cpu_model.op(4'(1 << k));
      cyc(0);
      check("cancel", {3'h0, sleep_cancel}, 4'h1);
      cyc(2);
      check("clk_en", {3'h0, cpu_clk_en}, 4'h1);
    end
    wr(`ILP_ADDR_TIMER, 4'h0);
    for (int e = 0; e < 2; e++)
    begin
      wr(`ILP_ADDR_CTRL0, 4'(8 + e));
      u_ilp_cpu_model.op(4'h1);
      cyc(2);
      check("clk_en", {3'h0, cpu_clk_en}, 4'h0);
      check("osc", {3'h0, osc_run}, 4'h1);
      check("hold", {3'h0, port_hold}, 4'h1);
      u_ilp_cpu_model.ev(5'h08);
      cyc(3);
      check("clk_en", {3'h0, cpu_clk_en}, 4'h1);
      check("hold", {3'h0, port_hold}, 4'h0);
      check("irq_req", {3'h0, irq_req}, 4'h0);
      u_ilp_cpu_model.op(4'h8);
      cyc(2);
      check("irq_req", {3'h0, irq_req}, 4'(e));
      if (e == 1)
      begin
        u_ilp_cpu_model.take_dly = 3;
        u_ilp_cpu_model.auto_take = 1'b1;
        cyc(8);
        check("irq_req", {3'h0, irq_req}, 4'h0);
      end
      rd(`ILP_ADDR_TIMER, 4'h1);
      wr(`ILP_ADDR_TIMER, 4'h0);
    end
    u_ilp_cpu_model.release_stop(4);
    cyc(4);
    check("restart", 4'(restarts), 4'h0);
    check("kept", {3'h0, ram_kept_flag}, 4'h0);
    u_ilp_cpu_model.op(4'h2);
    cyc(2);
    check("osc", {3'h0, osc_run}, 4'h0);
    check("preset", {3'h0, periph_reset}, 4'h1);
    check("clk_en", {3'h0, cpu_clk_en}, 4'h0);
    u_ilp_cpu_model.ev(5'h0F);
    u_ilp_cpu_model.release_stop(6);
    cyc(3);
    check("restart", 4'(restarts), 4'h1);
    check("clk_en", {3'h0, cpu_clk_en}, 4'h1);
    check("preset", {3'h0, periph_reset}, 4'h0);
    check("osc", {3'h0, osc_run}, 4'h1);
    rd(`ILP_ADDR_RAMKEPT, 4'h8);
    rd(`ILP_ADDR_TIMER, 4'hA);
    u_ilp_cpu_model.op(4'h2);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`ILP_ADDR_RAMKEPT, 4'h0);
    check("osc", {3'h0, osc_run}, 4'h1);
    end_sim();
  end
endmodule
